// [bench/power_mode_control_properties.sv]
// port assertions for the power mode controller
`timescale 1ns/1ps
module power_mode_control_properties #(
   parameter int NUM_PORTS = 2
) (
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic [NUM_PORTS-1:0] CABLE_ENERGY,
   input wire logic [NUM_PORTS-1:0] PORT_PWR_DOWN,
   input wire logic [NUM_PORTS-1:0] MIIM_PWR_DOWN,
   input wire logic PLL_CLK_EN,
   input wire logic MAC_EN,
   input wire logic HOST_IF_EN,
   input wire logic [NUM_PORTS-1:0] PHY_TX_EN,
   input wire logic [NUM_PORTS-1:0] PHY_RX_EN,
   input wire logic [NUM_PORTS-1:0] PHY_PORT_OFF,
   input wire logic LINK_PULSE,
   input wire logic LOW_POWER,
   input wire logic INT_RESET
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   // soft power-down: clocks off but not the energy sleep state
   wire soft_pd = !PLL_CLK_EN && !LOW_POWER && !INT_RESET;
   // write to the power mode register
   wire mode_wr = REG_WR && REG_ADDR == pmc_pkg::ADDR_PWR_MODE;
   // awake write of a mode other than soft power-down, then a read of it
   sequence set_then_read;
      mode_wr && PLL_CLK_EN && REG_WDATA[4:3] != 2'h2 ##1 REG_RD && !REG_WR && REG_ADDR == pmc_pkg::ADDR_PWR_MODE;
   endsequence
   sequence pulse_body;
      LINK_PULSE [*5] ##1 !LINK_PULSE;
   endsequence
   // sync delay bounds how long energy takes to wake the block
   sequence back_awake;
      ##[1:4] !LOW_POWER && PLL_CLK_EN && MAC_EN;
   endsequence
   mode_readback_a: assert property (set_then_read |=> REG_RDATA == {3'h0, $past(REG_WDATA[4:3], 2), 3'h0})
      else $error("mode field read back differs");
   read_answer_a: assert property (REG_RD |=> REG_RVALID)
      else $error("read got no answer");
   soft_off_a: assert property (mode_wr && PLL_CLK_EN && REG_WDATA[4:3] == 2'h2 |=>
      !PLL_CLK_EN && !MAC_EN && !HOST_IF_EN && (PHY_TX_EN | PHY_RX_EN) == '0) else $error("soft power-down left a block on");
   wake_reset_a: assert property (soft_pd && (REG_RD || REG_WR) |=> INT_RESET && PLL_CLK_EN ##1 !INT_RESET)
      else $error("host access did not wake with one reset pulse");
   reset_cause_a: assert property ($rose(INT_RESET) |-> $past(soft_pd))
      else $error("internal reset without soft power-down");
   dummy_read_a: assert property (soft_pd && REG_RD |=> REG_RDATA == 8'h00)
      else $error("waking read returned data");
   pulse_width_a: assert property ($rose(LINK_PULSE) |-> pulse_body)
      else $error("link pulse width wrong");
   sleep_gates_a: assert property (LOW_POWER |-> !PLL_CLK_EN && !MAC_EN && !HOST_IF_EN && (PHY_TX_EN | PHY_RX_EN) == '0)
      else $error("low power state left a block on");
   energy_wake_a: assert property (LOW_POWER && CABLE_ENERGY != '0 |-> back_awake)
      else $error("cable energy did not wake");
   port_off_a: assert property (1'b1 |=> PHY_PORT_OFF == $past(PORT_PWR_DOWN | MIIM_PWR_DOWN) &&
      (PHY_PORT_OFF & (PHY_TX_EN | PHY_RX_EN)) == '0) else $error("port power-down not followed");
endmodule
bind power_mode_control power_mode_control_properties #(.NUM_PORTS(NUM_PORTS)) i_props (
   .CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .CABLE_ENERGY(CABLE_ENERGY),
   .PORT_PWR_DOWN(PORT_PWR_DOWN), .MIIM_PWR_DOWN(MIIM_PWR_DOWN), .PLL_CLK_EN(PLL_CLK_EN), .MAC_EN(MAC_EN),
   .HOST_IF_EN(HOST_IF_EN), .PHY_TX_EN(PHY_TX_EN), .PHY_RX_EN(PHY_RX_EN), .PHY_PORT_OFF(PHY_PORT_OFF),
   .LINK_PULSE(LINK_PULSE), .LOW_POWER(LOW_POWER), .INT_RESET(INT_RESET));

// [bench/tb_power_mode_control.sv]
// self-checking bench for the power mode controller
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_power_mode_control;
   localparam int LP = 200; // short link pulse period
   localparam int SS = 20; // short timeout step
   localparam int TO = 51; // idle timeout used here
   logic CLOCK, RESETN, REG_WR, REG_RD, REG_RVALID;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
   logic [1:0] CABLE_ENERGY, LINK_UP, AN_ENABLE, PORT_PWR_DOWN, MIIM_PWR_DOWN;
   logic PLL_CLK_EN, MAC_EN, HOST_IF_EN, LINK_PULSE, LOW_POWER, INT_RESET;
   logic [1:0] PHY_TX_EN, PHY_RX_EN, PHY_ENERGY_DET_EN, PHY_PORT_OFF;
   int miscompares, n_compared, k;
   // enables gathered for one compare
   wire [6:0] en_vec = {PLL_CLK_EN, MAC_EN, HOST_IF_EN, PHY_TX_EN, PHY_RX_EN};
   power_mode_control #(.NUM_PORTS(2), .LINK_PERIOD_CYC(LP), .SLEEP_STEP_CYC(SS)) i_dut (
      .CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
      .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .CABLE_ENERGY(CABLE_ENERGY),
      .LINK_UP(LINK_UP), .AN_ENABLE(AN_ENABLE), .PORT_PWR_DOWN(PORT_PWR_DOWN), .MIIM_PWR_DOWN(MIIM_PWR_DOWN),
      .PLL_CLK_EN(PLL_CLK_EN), .MAC_EN(MAC_EN), .HOST_IF_EN(HOST_IF_EN), .PHY_TX_EN(PHY_TX_EN),
      .PHY_RX_EN(PHY_RX_EN), .PHY_ENERGY_DET_EN(PHY_ENERGY_DET_EN), .PHY_PORT_OFF(PHY_PORT_OFF),
      .LINK_PULSE(LINK_PULSE), .LOW_POWER(LOW_POWER), .INT_RESET(INT_RESET));
   // 40 MHz clock
   initial begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end
   // inputs move 2 ns after the edge, clear of sampling; idle cycles drop the strobes
   task tick(input int n);
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      repeat (n) @(posedge CLOCK);
      #2;
   endtask
   // strobe stays up until the next call or tick, so back to back
   // accesses never lower and raise it in one time step
   task wr(input logic [7:0] a, input logic [7:0] d);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_RD = 1'b0;
      REG_WR = 1'b1;
      @(posedge CLOCK);
      #2;
   endtask
   // answer comes one cycle after the strobe
   task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      REG_ADDR = a;
      REG_WR = 1'b0;
      REG_RD = 1'b1;
      @(posedge CLOCK);
      #2;
      `CHECK("read valid", 1'b1, REG_RVALID)
      `CHECK(nm, exp, REG_RDATA)
   endtask
   // bounded wait on the link pulse or the sleep flag
   task wait_sig(input bit sel, input logic val, input int lim);
      int n;
      n = 0;
      while (((sel ? LINK_PULSE : LOW_POWER) !== val) && n < lim) begin
         tick(1);
         n++;
      end
      if (n >= lim) begin
         miscompares++;
         $display("wrong value wait expected %h seen timeout", val);
         final_report();
      end
   endtask
   task final_report;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      {RESETN, REG_ADDR, REG_WDATA} = '0;
      {CABLE_ENERGY, LINK_UP, AN_ENABLE, PORT_PWR_DOWN, MIIM_PWR_DOWN} = '0;
      miscompares = 0;
      n_compared = 0;
      tick(6);
      RESETN = 1'b1;
      // defaults, unmapped offset reads zero
      `CHECK("enables", 7'h7f, en_vec)
      rd(8'h0e, 8'h00, "mode");
      rd(8'h0f, 8'h50, "timeout");
      rd(8'h10, 8'h00, "unmapped");
      wr(8'h0f, TO[7:0]);
      // power saving straight from normal, stray bits dropped
      AN_ENABLE = 2'b11;
      wr(8'h0e, 8'hff);
      rd(8'h0e, 8'h18, "mode");
      tick(3);
      `CHECK("saving", 7'h7c, en_vec)
      AN_ENABLE = 2'b01;
      tick(2);
      `CHECK("saving no autoneg", 7'h7e, en_vec)
      LINK_UP = 2'b01;
      tick(4);
      `CHECK("saving line up", 7'h7f, en_vec)
      LINK_UP = 2'b00;
      AN_ENABLE = 2'b11;
      tick(4);
      `CHECK("saving again", 7'h7c, en_vec)
      rd(8'h0f, TO[7:0], "timeout kept");
      // energy detect from power saving; energy held so no sleep yet
      CABLE_ENERGY = 2'b01;
      wr(8'h0e, 8'h08);
      rd(8'h0e, 8'h08, "mode");
      wait_sig(1'b1, 1'b1, LP + 50);
      k = 0;
      while (LINK_PULSE === 1'b1 && k < LP) begin
         tick(1);
         k++;
      end
      `CHECK("pulse width", 5, k)
      while (LINK_PULSE !== 1'b1 && k < 2 * LP) begin
         tick(1);
         k++;
      end
      `CHECK("pulse period", LP, k)
      // a short energy burst mid-count must restart the idle count
      CABLE_ENERGY = 2'b00;
      tick(600);
      CABLE_ENERGY = 2'b01;
      tick(5);
      CABLE_ENERGY = 2'b00;
      tick((TO + 1) * SS);
      `CHECK("early sleep", 1'b0, LOW_POWER)
      wait_sig(1'b0, 1'b1, 3 * SS);
      `CHECK("asleep", 7'h00, en_vec)
      `CHECK("detector", 2'b11, PHY_ENERGY_DET_EN)
      CABLE_ENERGY = 2'b10;
      wait_sig(1'b0, 1'b0, 6);
      `CHECK("awake", 7'h7f, en_vec)
      CABLE_ENERGY = 2'b00;
      // soft power-down, woken by a read then by a write
      wr(8'h0e, 8'h10);
      `CHECK("soft off", 7'h00, en_vec)
      `CHECK("soft detector", 2'b00, PHY_ENERGY_DET_EN)
      rd(8'h0e, 8'h00, "dummy read");
      `CHECK("int reset", 1'b1, INT_RESET)
      tick(1);
      `CHECK("int reset end", 1'b0, INT_RESET)
      rd(8'h0f, 8'h50, "timeout restored");
      `CHECK("woken", 7'h7f, en_vec)
      wr(8'h0e, 8'h10);
      wr(8'h0f, 8'h44);
      `CHECK("int reset", 1'b1, INT_RESET)
      rd(8'h0f, 8'h50, "dropped write");
      // per-port power-down from either control bit
      PORT_PWR_DOWN = 2'b01;
      tick(1);
      `CHECK("port off", 2'b01, PHY_PORT_OFF)
      `CHECK("port tx", 2'b10, PHY_TX_EN)
      PORT_PWR_DOWN = 2'b00;
      MIIM_PWR_DOWN = 2'b10;
      tick(1);
      `CHECK("miim off", 2'b10, PHY_PORT_OFF)
      final_report();
   end
endmodule

// [hw/pmc_pulse_timer.sv]
// period timer, counting only while run is high, that pulses at the end of each period
`timescale 1ns/1ps

module pmc_pulse_timer #(
   parameter int PERIOD = 40_000,
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic run,
   output logic pulse
);

   localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
   localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
   localparam logic [CW-1:0] HIGH_FROM = CW'(PERIOD - WIDTH);

   // counter and registered pulse
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic pulse;
   } tmr_t;

   tmr_t r_ff;
   tmr_t nxt_r;

   // pulse sits at the tail of the period, so a fresh start never fires at once
   always_comb begin
      nxt_r = r_ff;
      if (!run) begin
         nxt_r.cnt = '0;
         nxt_r.pulse = 1'b0;
      end else begin
         nxt_r.cnt = (r_ff.cnt == LAST) ? '0 : r_ff.cnt + 1'b1;
         nxt_r.pulse = (r_ff.cnt >= HIGH_FROM);
      end
   end

   // register stage
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign pulse = r_ff.pulse;

endmodule

// [hw/pmc_sync2.sv]
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps

module pmc_sync2 #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   // first stage feeds only the second stage
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_t;

   sync_t r_ff;
   sync_t nxt_r;

   // shift the pin level through both stages
   always_comb begin
      nxt_r.meta = din;
      nxt_r.stable = r_ff.meta;
   end

   // register stage
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign dout = r_ff.stable;

endmodule

// [hw/power_mode_control.sv]
// power mode controller: mode register, idle timeout, wake and block enables
`timescale 1ns/1ps

// Behaviour
// R1: mode field bits 4:3 selects power mode
// R2: reset leaves mode field at normal
// R3: normal keeps clocks, PHY, MAC, host on
// R4: host may leave normal for any mode
// R5: power saving gates only unused PHY receive
// R6: energy low-power keeps only energy detector
// R7: energy mode emits 120ns pulse each second
// R8: sleep after idle exceeds timeout field
// R9: cable energy wakes back to normal power
// R10: soft power-down stops clocks, PHY, MAC
// R11: host access wakes and resets registers
// R12: saving needs autoneg on, cable unplugged
// R13: saving keeps registers and PHY transmitter
// R14: line activity restores full PHY power
// R15: host may leave power saving freely
// R16: port bit or MIIM bit powers port down
// R17: waking access is dummy, data dropped
// R18: cable energy restarts the idle count
module power_mode_control #(
   parameter int NUM_PORTS = 2,
   parameter int LINK_PERIOD_CYC = pmc_pkg::LINK_PERIOD_CYC,
   parameter int SLEEP_STEP_CYC = pmc_pkg::SLEEP_STEP_CYC
) (
   input wire logic CLOCK,
   input wire logic RESETN,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   // per-port status from the analog side, asynchronous
   input wire logic [NUM_PORTS-1:0] CABLE_ENERGY,
   input wire logic [NUM_PORTS-1:0] LINK_UP,
   // per-port configuration from the port registers, same clock
   input wire logic [NUM_PORTS-1:0] AN_ENABLE,
   input wire logic [NUM_PORTS-1:0] PORT_PWR_DOWN,
   input wire logic [NUM_PORTS-1:0] MIIM_PWR_DOWN,
   // block enables
   output logic PLL_CLK_EN,
   output logic MAC_EN,
   output logic HOST_IF_EN,
   output logic [NUM_PORTS-1:0] PHY_TX_EN,
   output logic [NUM_PORTS-1:0] PHY_RX_EN,
   output logic [NUM_PORTS-1:0] PHY_ENERGY_DET_EN,
   output logic [NUM_PORTS-1:0] PHY_PORT_OFF,
   // status and events
   output logic LINK_PULSE,
   output logic LOW_POWER,
   output logic INT_RESET
);

   // energy detect sub-states
   // awake counts quiet steps, asleep only waits for energy
   typedef enum logic {ED_AWAKE, ED_ASLEEP} ed_state_t;

   // whole module state
   typedef struct packed {
      pmc_pkg::pwr_mode_t mode;               // power mode field
      logic [7:0] sleep_to;                   // idle timeout field
      ed_state_t ed;                          // energy detect sub-state
      logic [pmc_pkg::IDLE_CNT_W-1:0] idle;   // idle steps seen
      // registered block enables, one field per output
      logic pll_en;
      logic mac_en;
      logic host_en;
      logic [NUM_PORTS-1:0] tx_en;
      logic [NUM_PORTS-1:0] rx_en;
      logic [NUM_PORTS-1:0] ed_en;
      logic [NUM_PORTS-1:0] port_off;
      // status and event outputs
      logic link_pulse;
      logic low_power;
      logic int_rst;
      // read answer; data held until the next read returns or a waking access clears it, valid lasts one cycle
      logic [7:0] rdata;
      logic rvalid;
   } state_t;

   // current state and the value it takes at the next edge
   state_t r_ff;
   state_t nxt_r;

   // helper nets between the sub-blocks and the next-state logic
   logic [NUM_PORTS-1:0] energy_s;   // synchronised cable energy
   logic [NUM_PORTS-1:0] link_s;     // synchronised link status
   logic step_tick;                  // one idle step elapsed
   logic pulse_raw;                  // link pulse from its timer
   logic energy_any;                 // energy on any port
   logic idle_run;                   // idle step timer running
   logic in_energy;                  // energy detect mode selected

   // core blocks powered for this mode and sub-state
   // pll, mac and host interface share one switch; no mode splits them, so
   // one answer serves all three and the enables can never disagree
   function automatic logic core_on(input pmc_pkg::pwr_mode_t m, input ed_state_t e);
      logic on;
      on = 1'b0;
      unique case (m)
         pmc_pkg::MODE_NORMAL: on = 1'b1;       // R3
         pmc_pkg::MODE_SAVE: on = 1'b1;         // R5
         pmc_pkg::MODE_ENERGY: on = (e == ED_AWAKE);  // R6
         pmc_pkg::MODE_SOFT_PD: on = 1'b0;      // R10
      endcase
      return on;
   endfunction

   // read mux, unmapped offsets read as zero
   // only the mode field of the power register is stored; its other bits read zero
   function automatic logic [7:0] reg_read(input logic [7:0] a, input pmc_pkg::pwr_mode_t m,
                                           input logic [7:0] t);
      logic [7:0] d;
      d = 8'h00;
      if (a == pmc_pkg::ADDR_PWR_MODE) begin
         d[pmc_pkg::MODE_MSB:pmc_pkg::MODE_LSB] = m;
      end else if (a == pmc_pkg::ADDR_SLEEP_TO) begin
         d = t;
      end
      return d;
   endfunction

   // both analog status groups cross in one synchroniser
   // link status and cable energy come from the analog side with no
   // relation to this clock; two flops keep metastability out of the logic
   pmc_sync2 #(
      .W(2 * NUM_PORTS)
   ) u_sync (
      .clock(CLOCK),
      .resetn(RESETN),
      .din({LINK_UP, CABLE_ENERGY}),
      .dout({link_s, energy_s})
   );

   // one live port is enough to keep the whole device awake
   assign energy_any = |energy_s;
   // mode decode shared by both timers
   assign in_energy = (r_ff.mode == pmc_pkg::MODE_ENERGY);
   // step timer restarts whenever energy shows, so only quiet time counts
   assign idle_run = in_energy && (r_ff.ed == ED_AWAKE) && !energy_any;  // R18

   // idle step timer for the sleep timeout
   // it only makes ticks; the step count itself lives in the state struct
   pmc_pulse_timer #(
      .PERIOD(SLEEP_STEP_CYC),
      .WIDTH(pmc_pkg::SLEEP_TICK_CYC)
   ) u_step (
      .clock(CLOCK),
      .resetn(RESETN),
      .run(idle_run),
      .pulse(step_tick)
   );

   // link pulse generator, runs through both energy detect sub-states
   // the pulse sits at the end of each period, so entering the mode does
   // not fire one at once; all but the pulse width of a period passes first
   pmc_pulse_timer #(
      .PERIOD(LINK_PERIOD_CYC),
      .WIDTH(pmc_pkg::LINK_PULSE_CYC)
   ) u_link (
      .clock(CLOCK),
      .resetn(RESETN),
      .run(in_energy),   // R7
      .pulse(pulse_raw)
   );

   // next state: register port, energy detect sequencing, enables
   // locals are set at the top so no path leaves them holding an old value
   always_comb begin
      logic soft_wake;
      logic core;
      logic saving;
      soft_wake = 1'b0;
      core = 1'b0;
      saving = 1'b0;
      nxt_r = r_ff;
      nxt_r.rvalid = 1'b0;
      nxt_r.int_rst = 1'b0;

      // register access
      // a waking access is decoded from the stored mode, not from the host
      // enable output, so it works while that output is low
      soft_wake = (r_ff.mode == pmc_pkg::MODE_SOFT_PD) && (REG_WR || REG_RD);
      if (soft_wake) begin
         // any access wakes; contents return to their defaults
         nxt_r.mode = pmc_pkg::MODE_RST;      // R11
         // the timeout is the only other stored field, so the only one
         // that needs restoring here
         nxt_r.sleep_to = pmc_pkg::SLEEP_TO_RST;
         nxt_r.int_rst = 1'b1;                // R11
         // the access itself is dummy: write dropped, read gives zero
         nxt_r.rdata = 8'h00;                 // R17
         nxt_r.rvalid = REG_RD;
      end else begin
         // a write and a read in one cycle both take effect; the read
         // answers with the value from before the write
         if (REG_WR) begin
            // honoured from any mode but soft power-down, normal and saving included
            if (REG_ADDR == pmc_pkg::ADDR_PWR_MODE) begin
               nxt_r.mode = pmc_pkg::pwr_mode_t'(REG_WDATA[pmc_pkg::MODE_MSB:pmc_pkg::MODE_LSB]);  // R1 R4 R15
            end else if (REG_ADDR == pmc_pkg::ADDR_SLEEP_TO) begin
               nxt_r.sleep_to = REG_WDATA;
            end
         end
         if (REG_RD) begin
            nxt_r.rdata = reg_read(REG_ADDR, r_ff.mode, r_ff.sleep_to);
            nxt_r.rvalid = 1'b1;
         end
      end

      // energy detect sequencing
      // priority: mode exit, then wake, then fresh energy, then the step tick
      if (nxt_r.mode != pmc_pkg::MODE_ENERGY || soft_wake) begin
         // leaving the mode always lands awake with a clean count
         nxt_r.ed = ED_AWAKE;
         nxt_r.idle = '0;
      end else if (r_ff.ed == ED_ASLEEP) begin
         // no steps are counted asleep; only energy moves the state
         if (energy_any) begin
            nxt_r.ed = ED_AWAKE;               // R9
            nxt_r.idle = '0;
         end
      end else if (energy_any) begin
         nxt_r.idle = '0;                      // R18
      end else if (step_tick) begin
         // strictly longer than the programmed steps
         if (r_ff.idle > {1'b0, r_ff.sleep_to}) begin
            nxt_r.ed = ED_ASLEEP;              // R8
            nxt_r.idle = '0;
         end else begin
            nxt_r.idle = r_ff.idle + 1'b1;     // R8
         end
      end

      // block enables follow the mode being entered
      // taken from the next state, so enables change at the same edge as the
      // mode and never lag the register by a cycle
      core = core_on(nxt_r.mode, nxt_r.ed);
      nxt_r.pll_en = core;                     // R3 R6 R10
      nxt_r.mac_en = core;                     // R3 R6 R10
      nxt_r.host_en = core;                    // R3 R5 R6
      // port power-down beats every mode
      nxt_r.port_off = PORT_PWR_DOWN | MIIM_PWR_DOWN;  // R16
      for (int p = 0; p < NUM_PORTS; p++) begin
         // a port with link or energy is active and keeps its receiver
         // receive trimmed only with autoneg on, no link and a quiet line
         saving = (nxt_r.mode == pmc_pkg::MODE_SAVE) && AN_ENABLE[p] && !link_s[p] && !energy_s[p];  // R12 R14
         // transmitter stays up in power saving
         nxt_r.tx_en[p] = core && !nxt_r.port_off[p];             // R13
         nxt_r.rx_en[p] = core && !nxt_r.port_off[p] && !saving;  // R5
         // energy detector is the one piece alive in low power
         // it must stay up in saving mode as well, or activity could never
         // bring the receiver back
         nxt_r.ed_en[p] = (nxt_r.mode != pmc_pkg::MODE_SOFT_PD) && !nxt_r.port_off[p];  // R6 R10
      end
      // masked by the mode being entered: leaving the mode may cut a pulse short
      nxt_r.link_pulse = pulse_raw && (nxt_r.mode == pmc_pkg::MODE_ENERGY);  // R7
      // flag mirrors the asleep sub-state of energy detect mode
      nxt_r.low_power = (nxt_r.mode == pmc_pkg::MODE_ENERGY) && (nxt_r.ed == ED_ASLEEP);
   end

   // register stage; reset values match normal operation
   // constants only in the reset branch; enables come up on because
   // normal mode is the reset mode
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         r_ff.mode <= pmc_pkg::MODE_RST;       // R2
         r_ff.sleep_to <= pmc_pkg::SLEEP_TO_RST;
         r_ff.ed <= ED_AWAKE;
         r_ff.idle <= '0;
         r_ff.pll_en <= 1'b1;
         r_ff.mac_en <= 1'b1;
         r_ff.host_en <= 1'b1;
         r_ff.tx_en <= '1;
         r_ff.rx_en <= '1;
         r_ff.ed_en <= '1;
         r_ff.port_off <= '0;
         r_ff.link_pulse <= 1'b0;
         r_ff.low_power <= 1'b0;
         r_ff.int_rst <= 1'b0;
         r_ff.rdata <= pmc_pkg::RDATA_RST;
         r_ff.rvalid <= 1'b0;
      end else begin
         // the whole state moves as one
         r_ff <= nxt_r;
      end
   end

   // outputs straight from the state register
   // no logic after the flops, so the enables cannot glitch at the pins
   assign REG_RDATA = r_ff.rdata;
   assign REG_RVALID = r_ff.rvalid;
   assign PLL_CLK_EN = r_ff.pll_en;
   assign MAC_EN = r_ff.mac_en;
   assign HOST_IF_EN = r_ff.host_en;
   assign PHY_TX_EN = r_ff.tx_en;
   assign PHY_RX_EN = r_ff.rx_en;
   assign PHY_ENERGY_DET_EN = r_ff.ed_en;
   assign PHY_PORT_OFF = r_ff.port_off;
   assign LINK_PULSE = r_ff.link_pulse;
   assign LOW_POWER = r_ff.low_power;
   assign INT_RESET = r_ff.int_rst;

endmodule

// [inc/pmc_pkg.sv]
// constants and types shared by the power mode controller files
package pmc_pkg;

   // system clock rate, 40 MHz (25 ns)
   localparam int CLK_KHZ = 40_000;

   // register offsets on the register port
   localparam logic [7:0] ADDR_PWR_MODE = 8'h0e;
   localparam logic [7:0] ADDR_SLEEP_TO = 8'h0f;

   // mode field position in the power mode register
   localparam int MODE_LSB = 3;
   localparam int MODE_MSB = 4;

   // power mode encodings of the two-bit field
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_ENERGY = 2'h1,
      MODE_SOFT_PD = 2'h2,
      MODE_SAVE = 2'h3
   } pwr_mode_t;

   // values after reset
   localparam pwr_mode_t MODE_RST = MODE_NORMAL;
   localparam logic [7:0] SLEEP_TO_RST = 8'h50;
   localparam logic [7:0] RDATA_RST = 8'h00;

   // link pulse: 120 ns wide, least time so rounded up
   localparam int LINK_PULSE_NS = 120;
   localparam int LINK_PULSE_CYC_RAW = (LINK_PULSE_NS * CLK_KHZ + 999_999) / 1_000_000;
   localparam int LINK_PULSE_CYC = (LINK_PULSE_CYC_RAW < 1) ? 1 : LINK_PULSE_CYC_RAW;

   // link pulse repetition: one per second
   localparam int LINK_PERIOD_MS = 1000;
   localparam int LINK_PERIOD_CYC = LINK_PERIOD_MS * CLK_KHZ;

   // one step of the idle timeout field
   localparam int SLEEP_STEP_MS = 1;
   localparam int SLEEP_STEP_CYC = SLEEP_STEP_MS * CLK_KHZ;
   localparam int SLEEP_TICK_CYC = 1;

   // idle step counter, one bit wider than the timeout field
   localparam int IDLE_CNT_W = 9;

endpackage
